/* cpu_alu_defines.svh */
// What this block does
// - Exactly 41 instructions on 8-bit register data.
// - Operand by 8-bit address or 4-bit working number.
// - Register pair forms a 16-bit memory pointer.
// - Peripheral locations live inside the register file.
// - Seven addressing modes.
// - Full load group.
// - Calls, returns, conditional jumps.
// - Test under mask and complemented mask.
// - Rotates, rotates through carry, arithmetic right shift.
// - Eight-bit flags; upper four feed jump conditions.
// - Non-flag instructions may write flags as data.
// - Arithmetic and logic results update flags.
// - Overflow set outside signed eight-bit range.
// - Logic operations clear overflow.
// - Sign copies result most significant bit.
// - Zero set when result is all zeros.
// - Arithmetic carry marks carry out or borrow.
// - Rotate or shift carry holds last bit out.
// - Set, clear and invert carry instructions.
`ifndef CPU_ALU_DEFINES_SVH
`define CPU_ALU_DEFINES_SVH

// ==========================================================
// Special register addresses and reset values
// ==========================================================
`define FLAGS_ADDR 8'hd5
`define SP_ADDR 8'hd9
`define SYM_ADDR 8'hdf
`define PERIPH_BASE 8'he0
`define WORK_HI 4'hc
`define FLAGS_RST 8'h00
`define SP_RST 8'hc0
`define PC_RST 16'h0000

// ==========================================================
// Field positions
// ==========================================================
`define FLG_C 7
`define FLG_Z 6
`define FLG_S 5
`define FLG_V 4
`define SYM_IE 3

`endif

/* cpu_alu_pkg.sv */
package cpu_alu_pkg;

  // ==========================================================
  // Instruction repertoire, one code per instruction
  // ==========================================================
  typedef enum logic [5:0] {
    op_clear, op_load, op_load_program_memory, op_load_external_data,
    op_load_program_mem_dec, op_load_external_mem_dec,
    op_load_program_mem_inc, op_load_external_mem_inc, op_pop, op_push,
    op_add_carry, op_add, op_compare, op_dec, op_inc, op_sub_carry,
    op_sub, op_and, op_complement, op_or, op_xor, op_call,
    op_return_from_interrupt, op_jump, op_jump_relative, op_return,
    op_test_inverted_mask, op_mask_test, op_rotate_left,
    op_rotate_left_via_carry, op_rotate_right, op_rotate_right_via_carry,
    op_arith_shift_right, op_invert_carry_op, op_mask_all_interrupts,
    op_global_interrupt_on, op_enter_idle, op_nop, op_clear_carry_op,
    op_set_carry_op, op_enter_stop
  } op_t;

  typedef enum logic [2:0] {
    am_reg, am_work, am_ind, am_idx, am_da, am_ra, am_imm
  } amode_t;

  typedef enum logic [2:0] {
    s_idle = 3'b000,
    s_sptr = 3'b001,
    s_dptr = 3'b011,
    s_opnd = 3'b010,
    s_exec = 3'b110,
    s_mem = 3'b111
  } state_t;

  typedef struct packed {
    logic valid;
    op_t op;
    amode_t dmode;
    amode_t smode;
    logic [3:0] cc;
    logic [7:0] dst;
    logic [7:0] src;
    logic [15:0] addr;
    logic [15:0] nxt;
  } instr_t;

  typedef struct packed {
    logic valid;
    logic prog;
    logic [15:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  // Flag vectors are ordered carry, zero, sign, overflow.
  typedef struct packed {
    logic [7:0] res;
    logic [3:0] f;
    logic [3:0] upd;
    logic wr;
  } alu_t;

  typedef struct packed {
    state_t st;
    instr_t ins;
    logic [15:0] pa;
    logic [7:0] sa;
    logic [7:0] da;
    logic [7:0] rqa;
    logic [7:0] rqb;
    logic [7:0] flags;
    logic ie;
    logic [7:0] sp;
    logic [15:0] pc;
    logic rdy;
    logic upd_rdy;
    logic idle;
    logic stop;
    mem_req_t mem;
    reg_wr_t pwr;
  } core_t;

endpackage

/* cpu_alu_status_flags.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpu_alu_defines.svh"
module cpu_alu_status_flags (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire cpu_alu_pkg::instr_t i_instr,
  input wire logic i_mem_ack,
  input wire logic [7:0] i_mem_rdata,
  input wire cpu_alu_pkg::reg_wr_t i_periph_upd,
  output logic o_ready,
  output logic o_upd_ready,
  output logic [7:0] o_flags,
  output logic [15:0] o_pc,
  output logic o_int_enable,
  output logic o_idle,
  output logic o_stop,
  output cpu_alu_pkg::mem_req_t o_mem,
  output cpu_alu_pkg::reg_wr_t o_periph_wr
);
  import cpu_alu_pkg::*;

  core_t q;
  core_t d;
  alu_t alu;
  logic [7:0] ra;
  logic [7:0] rb;
  logic [7:0] rda;
  logic [7:0] rdb;
  logic [7:0] va;
  logic [7:0] vb;
  logic [7:0] sv;
  logic [7:0] dv;
  logic [15:0] tgt;
  logic we;
  logic wpair;
  logic [7:0] wa;
  logic [15:0] wd;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_val;
  logic fl_en;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Working registers form one 16-byte bank.
  function automatic logic [7:0] reg_addr(amode_t m, logic [7:0] v);
    return (m == am_work) ? {`WORK_HI, v[3:0]} : v;
  endfunction

  // Pointer location: the index of an indexed operand is always a
  // working register, as is a working-number pointer; any other names a full address.
  function automatic logic [7:0] ptr_addr(amode_t m, logic [7:0] v);
    return (m == am_idx) ? {`WORK_HI, v[3:0]} : reg_addr(m, v);
  endfunction

  // Effective register address.
  function automatic logic [7:0] eff_addr(amode_t m, logic [7:0] v,
                                          logic [7:0] off,
                                          logic [7:0] ptr);
    logic [7:0] e;
    case (m)
      am_ind: e = ptr;
      am_idx: e = 8'(off + ptr);
      default: e = reg_addr(m, v);
    endcase
    return e;
  endfunction

  // Special locations are flops, the rest is memory.
  function automatic logic [7:0] rd_mux(logic [7:0] a, logic [7:0] m,
                                        core_t c);
    logic [7:0] r;
    case (a)
      `FLAGS_ADDR: r = c.flags;
      `SYM_ADDR: r = 8'({7'h00, c.ie} << `SYM_IE);
      `SP_ADDR: r = c.sp;
      default: r = m;
    endcase
    return r;
  endfunction

  // Condition test on the upper four flags, bit 3 inverts the sense.
  function automatic logic cond_f(logic [3:0] cc, logic [7:0] fl);
    logic t;
    logic lt;
    lt = fl[`FLG_S] ^ fl[`FLG_V];
    case (cc[2:0])
      3'h0: t = 1'b1;
      3'h1: t = fl[`FLG_C];
      3'h2: t = fl[`FLG_Z];
      3'h3: t = fl[`FLG_S];
      3'h4: t = fl[`FLG_V];
      3'h5: t = lt;
      3'h6: t = fl[`FLG_Z] | lt;
      default: t = fl[`FLG_C] | fl[`FLG_Z];
    endcase
    return t ^ cc[3];
  endfunction

  // Result and flag outcome of one data operation.
  function automatic alu_t alu_f(op_t op, logic [7:0] x, logic [7:0] y,
                                 logic c);
    alu_t a;
    logic [8:0] w;
    a.res = y;
    a.f = 4'h0;
    a.upd = 4'h0;
    a.wr = 1'b0;
    w = 9'h000;
    case (op)
      op_add, op_add_carry: begin
        w = {1'b0, x} + {1'b0, y} + {8'h00, c & (op == op_add_carry)};
        a.res = w[7:0];
        a.f[3] = w[8];
        a.f[0] = (x[7] == y[7]) && (w[7] != x[7]);
        a.upd = 4'hf;
        a.wr = 1'b1;
      end
      op_sub, op_sub_carry, op_compare: begin
        w = {1'b0, x} - {1'b0, y} - {8'h00, c & (op == op_sub_carry)};
        a.res = w[7:0];
        a.f[3] = w[8];
        a.f[0] = (x[7] != y[7]) && (w[7] != x[7]);
        a.upd = 4'hf;
        a.wr = (op != op_compare);
      end
      op_inc, op_dec: begin
        a.res = (op == op_inc) ? 8'(x + 8'h01) : 8'(x - 8'h01);
        a.f[0] = (op == op_inc) ? (x == 8'h7f) : (x == 8'h80);
        a.upd = 4'h7;
        a.wr = 1'b1;
      end
      op_and, op_or, op_xor, op_complement: begin
        case (op)
          op_and: a.res = x & y;
          op_or: a.res = x | y;
          op_xor: a.res = x ^ y;
          default: a.res = ~x;
        endcase
        a.upd = 4'h7;
        a.wr = 1'b1;
      end
      op_mask_test, op_test_inverted_mask: begin
        a.res = (op == op_mask_test) ? (x & y) : (~x & y);
        a.upd = 4'h7;
      end
      op_rotate_left, op_rotate_left_via_carry: begin
        a.res = {x[6:0], (op == op_rotate_left) ? x[7] : c};
        a.f[3] = x[7];
        a.f[0] = a.res[7] ^ x[7];
        a.upd = 4'hf;
        a.wr = 1'b1;
      end
      op_rotate_right, op_rotate_right_via_carry,
      op_arith_shift_right: begin
        case (op)
          op_rotate_right: a.res = {x[0], x[7:1]};
          op_rotate_right_via_carry: a.res = {c, x[7:1]};
          default: a.res = {x[7], x[7:1]};
        endcase
        a.f[3] = x[0];
        a.f[0] = a.res[7] ^ x[7];
        a.upd = 4'hf;
        a.wr = 1'b1;
      end
      op_set_carry_op, op_clear_carry_op, op_invert_carry_op: begin
        a.f[3] = (op == op_set_carry_op) |
                 ((op == op_invert_carry_op) & ~c);
        a.upd = 4'h8;
      end
      op_clear: begin
        a.res = 8'h00;
        a.wr = 1'b1;
      end
      op_load, op_pop: a.wr = 1'b1;
      default: a.wr = 1'b0;
    endcase
    a.f[2] = (a.res == 8'h00);
    a.f[1] = a.res[7];
    return a;
  endfunction

  // ==========================================================
  // Register file
  // ==========================================================
  regfile_mem u_regs (
    .i_clk(i_clk),
    .i_rd_addr_a(ra),
    .i_rd_addr_b(rb),
    .i_we(we),
    .i_wpair(wpair),
    .i_waddr(wa),
    .i_wdata(wd),
    .o_rd_a(rda),
    .o_rd_b(rdb)
  );

  // ==========================================================
  // Next-state logic
  // ==========================================================
  // Each instruction walks pointer fetch, operand fetch and execute
  // at a fixed pace; the unused reads are harmless and keep the
  // sequencer free of per-mode branches.
  always_comb begin
    d = q;
    ra = 8'h00;
    rb = 8'h00;
    we = 1'b0;
    wpair = 1'b0;
    wa = 8'h00;
    wd = 16'h0000;
    wr_en = 1'b0;
    wr_addr = q.da;
    wr_val = 8'h00;
    fl_en = 1'b0;
    d.idle = 1'b0;
    d.stop = 1'b0;
    d.pwr.valid = 1'b0;
    va = rd_mux(q.rqa, rda, q);
    vb = rd_mux(q.rqb, rdb, q);
    sv = (q.ins.smode == am_imm) ? q.ins.src : va;
    dv = vb;
    alu = alu_f(q.ins.op, dv, sv, q.flags[`FLG_C]);
    tgt = (q.ins.smode == am_da) ? q.ins.addr : q.pa;
    case (q.st)
      s_idle: begin
        if (i_instr.valid && q.rdy) begin
          d.ins = i_instr;
          d.st = s_sptr;
        end
      end
      s_sptr: begin
        // Stack reads start at the stack pointer.
        case (q.ins.op)
          op_pop, op_return, op_return_from_interrupt: ra = q.sp;
          default: ra = ptr_addr(q.ins.smode, q.ins.src);
        endcase
        rb = 8'(ra + 8'h01);
        d.st = s_dptr;
      end
      s_dptr: begin
        d.pa = {va, vb};
        case (q.ins.op)
          op_pop: d.sa = q.sp;
          op_return_from_interrupt: d.sa = 8'(q.sp + 8'h02);
          default: d.sa = eff_addr(q.ins.smode, q.ins.src,
                                   q.ins.addr[7:0], va);
        endcase
        ra = ptr_addr(q.ins.dmode, q.ins.dst);
        d.st = s_opnd;
      end
      s_opnd: begin
        d.da = eff_addr(q.ins.dmode, q.ins.dst, q.ins.addr[7:0], va);
        ra = q.sa;
        rb = d.da;
        d.st = s_exec;
      end
      s_exec: begin
        d.pc = q.ins.nxt;
        d.st = s_idle;
        case (q.ins.op)
          op_push: begin
            d.sp = 8'(q.sp - 8'h01);
            wr_en = 1'b1;
            wr_addr = d.sp;
            wr_val = sv;
          end
          op_load_program_memory, op_load_external_data,
          op_load_program_mem_dec, op_load_external_mem_dec,
          op_load_program_mem_inc, op_load_external_mem_inc: begin
            d.mem.valid = 1'b1;
            d.mem.addr = q.pa;
            d.mem.prog = (q.ins.op == op_load_program_memory) ||
                         (q.ins.op == op_load_program_mem_dec) ||
                         (q.ins.op == op_load_program_mem_inc);
            d.st = s_mem;
            // Pointer steps now; the request already holds the old one.
            case (q.ins.op)
              op_load_program_mem_dec, op_load_external_mem_dec: begin
                we = 1'b1;
                wd = q.pa - 16'h0001;
              end
              op_load_program_mem_inc, op_load_external_mem_inc: begin
                we = 1'b1;
                wd = q.pa + 16'h0001;
              end
              default: we = 1'b0;
            endcase
            wpair = we;
            wa = reg_addr(q.ins.smode, q.ins.src);
          end
          op_call: begin
            d.sp = 8'(q.sp - 8'h02);
            we = 1'b1;
            wpair = 1'b1;
            wa = d.sp;
            wd = q.ins.nxt;
            d.pc = tgt;
          end
          op_return: begin
            d.sp = 8'(q.sp + 8'h02);
            d.pc = q.pa;
          end
          op_jump: begin
            if (cond_f(q.ins.cc, q.flags)) begin
              d.pc = tgt;
            end
          end
          op_jump_relative: begin
            if (cond_f(q.ins.cc, q.flags)) begin
              d.pc = q.ins.nxt +
                     {{8{q.ins.addr[7]}}, q.ins.addr[7:0]};
            end
          end
          op_return_from_interrupt: d.sp = 8'(q.sp + 8'h03);
          op_global_interrupt_on: d.ie = 1'b1;
          op_mask_all_interrupts: d.ie = 1'b0;
          op_enter_idle: d.idle = 1'b1;
          op_enter_stop: d.stop = 1'b1;
          op_nop: d.ie = q.ie;
          default: begin
            if (q.ins.op == op_pop) begin
              d.sp = 8'(q.sp + 8'h01);
            end
            wr_en = alu.wr;
            wr_val = alu.res;
            fl_en = 1'b1;
          end
        endcase
      end
      s_mem: begin
        if (i_mem_ack) begin
          d.mem.valid = 1'b0;
          wr_en = 1'b1;
          wr_val = i_mem_rdata;
          d.st = s_idle;
        end
      end
      default: d.st = s_idle;
    endcase
    // One byte write; the top window is also shown to the peripherals.
    if (wr_en) begin
      case (wr_addr)
        `FLAGS_ADDR: d.flags = wr_val;
        `SYM_ADDR: d.ie = wr_val[`SYM_IE];
        `SP_ADDR: d.sp = wr_val;
        default: begin
          we = 1'b1;
          wa = wr_addr;
          wd = {8'h00, wr_val};
        end
      endcase
      if (wr_addr >= `PERIPH_BASE) begin
        d.pwr.valid = 1'b1;
        d.pwr.addr = wr_addr;
        d.pwr.data = wr_val;
      end
    end
    // Flag update comes after the data write, so it wins if software
    // points a flag-updating operation at the flags location.
    if (fl_en) begin
      d.flags[7:4] = (d.flags[7:4] & ~alu.upd) |
                     (alu.f & alu.upd);
    end
    if (q.st == s_exec && q.ins.op == op_return_from_interrupt) begin
      d.flags = q.pa[15:8];
      d.pc = {q.pa[7:0], sv};
      d.ie = 1'b1;
    end
    // Peripheral status lands only while the core leaves the port free.
    if (q.upd_rdy && i_periph_upd.valid) begin
      we = 1'b1;
      wpair = 1'b0;
      wa = i_periph_upd.addr;
      wd = {8'h00, i_periph_upd.data};
    end
    d.rqa = ra;
    d.rqb = rb;
    d.rdy = (d.st == s_idle) && !(q.st == s_idle && i_instr.valid);
    d.upd_rdy = (d.st != s_exec) && (d.st != s_mem);
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
      q.flags <= `FLAGS_RST;
      q.sp <= `SP_RST;
      q.pc <= `PC_RST;
      q.rdy <= 1'b1;
      q.upd_rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_ready = q.rdy;
  assign o_upd_ready = q.upd_rdy;
  assign o_flags = q.flags;
  assign o_pc = q.pc;
  assign o_int_enable = q.ie;
  assign o_idle = q.idle;
  assign o_stop = q.stop;
  assign o_mem = q.mem;
  assign o_periph_wr = q.pwr;
endmodule
`default_nettype wire

/* cpu_alu_status_flags_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_alu_status_flags_chk (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire cpu_alu_pkg::instr_t i_instr,
  input wire logic i_mem_ack,
  input wire logic [7:0] i_mem_rdata,
  input wire cpu_alu_pkg::reg_wr_t i_periph_upd,
  input wire logic o_ready,
  input wire logic o_upd_ready,
  input wire logic [7:0] o_flags,
  input wire logic [15:0] o_pc,
  input wire logic o_int_enable,
  input wire logic o_idle,
  input wire logic o_stop,
  input wire cpu_alu_pkg::mem_req_t o_mem,
  input wire cpu_alu_pkg::reg_wr_t o_periph_wr
);
  import cpu_alu_pkg::*;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // ==========================================================
  // Helpers
  // ==========================================================
  // Memory loads end on acknowledge, so their pace is checked apart.
  logic take;
  logic mem_op;
  assign take = o_ready && i_instr.valid;
  assign mem_op = i_instr.op inside {op_load_program_memory,
    op_load_external_data, op_load_program_mem_dec,
    op_load_external_mem_dec, op_load_program_mem_inc,
    op_load_external_mem_inc};

  // ==========================================================
  // Properties
  // ==========================================================
  property p_pace;
    take && !mem_op && !(i_instr.op inside {op_enter_idle, op_enter_stop})
      |=> !o_ready [*4] ##1 o_ready;
  endproperty
  a_pace: assert property (p_pace)
    else $error("instruction pace wrong");

  property p_mem_req;
    take && mem_op |-> ##5 o_mem.valid;
  endproperty
  a_mem_req: assert property (p_mem_req)
    else $error("memory request missing");

  property p_mem_hold;
    o_mem.valid && !i_mem_ack |=> o_mem.valid && $stable(o_mem.addr);
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request dropped early");

  property p_mem_done;
    o_mem.valid && i_mem_ack |=> !o_mem.valid && o_ready;
  endproperty
  a_mem_done: assert property (p_mem_done)
    else $error("load not finished");

  property p_flags_hold;
    $changed(o_flags) |-> !$past(o_ready);
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("flags changed while idle");

  property p_pc_hold;
    $changed(o_pc) |-> !$past(o_ready);
  endproperty
  a_pc_hold: assert property (p_pc_hold)
    else $error("pc changed while idle");

  property p_carry_set;
    take && i_instr.op == op_set_carry_op
      |-> ##5 o_flags == ($past(o_flags, 5) | 8'h80);
  endproperty
  a_carry_set: assert property (p_carry_set)
    else $error("carry set wrong");

  property p_carry_inv;
    take && i_instr.op == op_invert_carry_op
      |-> ##5 o_flags == ($past(o_flags, 5) ^ 8'h80);
  endproperty
  a_carry_inv: assert property (p_carry_inv)
    else $error("carry invert wrong");

  property p_ie_on;
    take && i_instr.op == op_global_interrupt_on |-> ##5 o_int_enable;
  endproperty
  a_ie_on: assert property (p_ie_on)
    else $error("interrupt enable not set");

  property p_logic_v;
    take && i_instr.op inside {op_and, op_or, op_xor, op_complement}
      |-> ##5 !o_flags[4];
  endproperty
  a_logic_v: assert property (p_logic_v)
    else $error("logic op left overflow");

  property p_periph;
    o_periph_wr.valid |-> o_periph_wr.addr >= 8'he0 ##1 !o_periph_wr.valid;
  endproperty
  a_periph: assert property (p_periph)
    else $error("peripheral pulse wrong");
endmodule

bind cpu_alu_status_flags cpu_alu_status_flags_chk cpu_alu_status_flags_chk_i (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_instr(i_instr),
  .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
  .i_periph_upd(i_periph_upd), .o_ready(o_ready),
  .o_upd_ready(o_upd_ready), .o_flags(o_flags), .o_pc(o_pc),
  .o_int_enable(o_int_enable), .o_idle(o_idle), .o_stop(o_stop),
  .o_mem(o_mem), .o_periph_wr(o_periph_wr)
);
`default_nettype wire

/* cpu_alu_status_flags_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpu_alu_defines.svh"
module cpu_alu_status_flags_test;
  import cpu_alu_pkg::*;

  // ==========================================================
  // Signals
  // ==========================================================
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  instr_t i_instr = '0;
  logic i_mem_ack = 1'b0;
  logic [7:0] i_mem_rdata = 8'h00;
  reg_wr_t i_periph_upd = '0;
  logic o_ready, o_upd_ready, o_int_enable, o_idle, o_stop;
  logic [7:0] o_flags;
  logic [15:0] o_pc;
  mem_req_t o_mem;
  reg_wr_t o_periph_wr;
  int fails = 0;
  int compares = 0;
  logic seen_wr, seen_idle, seen_stop;
  logic [7:0] wr_data;
  logic [7:0] mem_data = 8'h00;
  logic [15:0] nxt_a = 16'h0202;
  mem_req_t mem_seen;

  typedef struct packed {
    op_t op;
    logic [7:0] fi, a, b, res, fo;
    logic wr;
  } row_t;

  // Each row: op, flags before, operand, immediate, result, flags after.
  row_t rows [28] = '{
    '{op_add, 8'h00, 8'h7f, 8'h01, 8'h80, 8'h30, 1'b1},
    '{op_add, 8'h00, 8'hff, 8'h01, 8'h00, 8'hc0, 1'b1},
    '{op_add_carry, 8'h80, 8'h01, 8'h01, 8'h03, 8'h00, 1'b1},
    '{op_sub, 8'h00, 8'h00, 8'h01, 8'hff, 8'ha0, 1'b1},
    '{op_sub, 8'h00, 8'h80, 8'h01, 8'h7f, 8'h10, 1'b1},
    '{op_sub_carry, 8'h80, 8'h05, 8'h05, 8'hff, 8'ha0, 1'b1},
    '{op_compare, 8'h00, 8'h05, 8'h05, 8'h00, 8'h40, 1'b0},
    '{op_inc, 8'h80, 8'h7f, 8'h00, 8'h80, 8'hb0, 1'b1},
    '{op_dec, 8'h00, 8'h00, 8'h00, 8'hff, 8'h20, 1'b1},
    '{op_and, 8'h9a, 8'hf0, 8'h0f, 8'h00, 8'hca, 1'b1},
    '{op_or, 8'h1a, 8'h80, 8'h01, 8'h81, 8'h2a, 1'b1},
    '{op_xor, 8'hf0, 8'hff, 8'hff, 8'h00, 8'hc0, 1'b1},
    '{op_complement, 8'h10, 8'h0f, 8'h00, 8'hf0, 8'h20, 1'b1},
    '{op_rotate_left, 8'h00, 8'h81, 8'h00, 8'h03, 8'h90, 1'b1},
    '{op_rotate_left_via_carry, 8'h00, 8'h80, 8'h00, 8'h00, 8'hd0,
      1'b1},
    '{op_rotate_right, 8'h00, 8'h01, 8'h00, 8'h80, 8'hb0, 1'b1},
    '{op_rotate_right_via_carry, 8'h80, 8'h02, 8'h00, 8'h81, 8'h30,
      1'b1},
    '{op_arith_shift_right, 8'h00, 8'h81, 8'h00, 8'hc0, 8'ha0, 1'b1},
    '{op_mask_test, 8'h80, 8'h0f, 8'hf0, 8'h00, 8'hc0, 1'b0},
    '{op_mask_test, 8'hf0, 8'h0f, 8'h03, 8'h00, 8'h80, 1'b0},
    '{op_test_inverted_mask, 8'h00, 8'h0f, 8'h0f, 8'h00, 8'h40, 1'b0},
    '{op_set_carry_op, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 1'b0},
    '{op_clear_carry_op, 8'hff, 8'h00, 8'h00, 8'h00, 8'h7f, 1'b0},
    '{op_invert_carry_op, 8'h8f, 8'h00, 8'h00, 8'h00, 8'h0f, 1'b0},
    '{op_invert_carry_op, 8'h05, 8'h00, 8'h00, 8'h00, 8'h85, 1'b0},
    '{op_load, 8'hf5, 8'h00, 8'h5a, 8'h5a, 8'hf5, 1'b1},
    '{op_clear, 8'h7e, 8'h33, 8'h00, 8'h00, 8'h7e, 1'b1},
    '{op_nop, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h3c, 1'b0}
  };
  logic [7:0] fl [2] = '{8'h80, 8'h50};
  logic [7:0] tk [2] = '{8'h83, 8'hf5};
  op_t mop [4] = '{op_load_external_mem_inc, op_load_program_mem_dec,
    op_load_program_memory, op_load_external_data};
  logic [15:0] mad [4] = '{16'h1234, 16'h1235, 16'h1234, 16'h1234};
  logic [3:0] mpr = 4'b0110;
  logic [7:0] stk [3] = '{8'h78, 8'h56, 8'h3c};

  cpu_alu_status_flags cpu_alu_status_flags_i (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_instr(i_instr),
    .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
    .i_periph_upd(i_periph_upd), .o_ready(o_ready),
    .o_upd_ready(o_upd_ready), .o_flags(o_flags), .o_pc(o_pc),
    .o_int_enable(o_int_enable), .o_idle(o_idle), .o_stop(o_stop),
    .o_mem(o_mem), .o_periph_wr(o_periph_wr)
  );

  // ==========================================================
  // Tasks
  // ==========================================================
  // Clock of 25 ns.
  always #12.5 i_clk = ~i_clk;

  task automatic check8(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One-cycle pulses are latched as they pass.
  task automatic grab();
    if (o_periph_wr.valid) begin
      seen_wr = 1'b1;
      wr_data = o_periph_wr.data;
    end
    seen_idle |= o_idle;
    seen_stop |= o_stop;
  endtask

  // Peripheral byte write, held until taken.
  task automatic poke(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    i_periph_upd = '{1'b1, a, d};
    do @(posedge i_clk); while (!o_upd_ready);
    #1;
    i_periph_upd = '{1'b0, ~a, ~d};
  endtask

  // One instruction; memory answers on the third cycle.
  task automatic run(input op_t op, input logic [7:0] dst = 8'h00,
      input amode_t sm = am_imm, input logic [7:0] src = 8'h00,
      input logic [3:0] cc = 4'h0, input logic [15:0] adr = 16'h0000);
    int n;
    int w;
    @(posedge i_clk);
    #1;
    i_instr = '{1'b1, op, am_reg, sm, cc, dst, src, adr, nxt_a};
    do @(posedge i_clk); while (!o_ready);
    #1;
    i_instr.valid = 1'b0;
    seen_wr = 1'b0;
    seen_idle = 1'b0;
    seen_stop = 1'b0;
    mem_seen = '0;
    w = 0;
    for (n = 0; n < 40; n++) begin
      grab();
      if (o_mem.valid) begin
        mem_seen = o_mem;
        w++;
      end
      i_mem_ack = o_mem.valid && w == 3;
      i_mem_rdata = i_mem_ack ? mem_data : ~mem_data;
      if (o_ready) break;
      @(posedge i_clk);
      #1;
    end
    check8({7'h0, o_ready}, 8'h01);
    @(posedge i_clk);
    #1;
    grab();
  endtask

  // ==========================================================
  // Sequence
  // ==========================================================
  // Watchdog of 6000 cycles, sized well above the expected 840 or so.
  initial begin
    #150000;
    fails++;
    conclude();
  end

  // Reset, flag table, then hand-written cases.
  initial begin
    repeat (16) @(posedge i_clk);
    #1;
    i_arst_n = 1'b1;
    check8(o_flags, 8'h00);
    check8(o_pc, 16'h0000);
    check8({o_ready, o_upd_ready, o_int_enable, o_idle, o_stop,
      o_mem.valid, o_periph_wr.valid, 1'b0}, 8'hc0);
    foreach (rows[k]) begin
      run(op_load, `FLAGS_ADDR, am_imm, rows[k].fi);
      check8(o_flags, rows[k].fi);
      poke(8'he0, rows[k].a);
      run(rows[k].op, 8'he0, am_imm, rows[k].b);
      check8(o_flags, rows[k].fo);
      check8({7'h0, seen_wr}, {7'h0, rows[k].wr});
      if (rows[k].wr) check8(wr_data, rows[k].res);
    end
    for (int p = 0; p < 2; p++) begin
      run(op_load, `FLAGS_ADDR, am_imm, fl[p]);
      for (int c = 0; c < 16; c++) begin
        run(op_jump, 8'h00, am_da, 8'h00, c[3:0], 16'h2000 + 16'(c));
        check8(o_pc, (tk[p][c[2:0]] ^ c[3]) ? 16'h2000 + 16'(c) :
          nxt_a);
      end
    end
    run(op_jump_relative, 8'h00, am_ra, 8'h00, 4'h0, 16'h00fe);
    check8(o_pc, 16'h0200);
    run(op_call, 8'h00, am_da, 8'h00, 4'h0, 16'h4000);
    check8(o_pc, 16'h4000);
    run(op_return);
    check8(o_pc, 16'h0202);
    run(op_global_interrupt_on);
    check8({7'h0, o_int_enable}, 8'h01);
    run(op_mask_all_interrupts);
    check8({7'h0, o_int_enable}, 8'h00);
    foreach (stk[k]) begin
      poke(8'he0, stk[k]);
      run(op_push, 8'h00, am_reg, 8'he0);
    end
    run(op_return_from_interrupt, 8'h00, am_reg);
    check8(o_pc, 16'h5678);
    check8(o_flags, 8'h3c);
    check8({7'h0, o_int_enable}, 8'h01);
    run(op_load, 8'h20, am_imm, 8'h12);
    run(op_load, 8'h21, am_imm, 8'h34);
    foreach (mop[k]) begin
      mem_data = 8'h40 + 8'(k);
      run(mop[k], 8'he0, am_ind, 8'h20);
      check8(mem_seen.addr, mad[k]);
      check8({7'h0, mem_seen.prog}, {7'h0, mpr[k]});
      check8(wr_data, 8'h40 + 8'(k));
    end
    run(op_enter_idle);
    check8({7'h0, seen_idle}, 8'h01);
    run(op_enter_stop);
    check8({7'h0, seen_stop}, 8'h01);
    conclude();
  end
endmodule
`default_nettype wire

/* regfile_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module regfile_mem (
  input wire logic i_clk,
  input wire logic [7:0] i_rd_addr_a,
  input wire logic [7:0] i_rd_addr_b,
  input wire logic i_we,
  input wire logic i_wpair,
  input wire logic [7:0] i_waddr,
  input wire logic [15:0] i_wdata,
  output logic [7:0] o_rd_a,
  output logic [7:0] o_rd_b
);
  logic [7:0] mem_q [0:255];

  // ==========================================================
  // Storage
  // ==========================================================
  // A pair write puts the high byte at the given address, the low byte after it, so
  // stacked program counters and pointers stay big-endian.
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wpair ? i_wdata[15:8] : i_wdata[7:0];
      if (i_wpair) begin
        mem_q[8'(i_waddr + 8'h01)] <= i_wdata[7:0];
      end
    end
    o_rd_a <= mem_q[i_rd_addr_a];
    o_rd_b <= mem_q[i_rd_addr_b];
  end
endmodule
`default_nettype wire
